/* File: core/dmach_addr_step.v */
// next value of a working address after one word moved
`timescale 1ns/1ps
`include "dmach_defines.vh"
module dmach_addr_step (
  addr,
  mode,
  next_addr
);
  input wire [31:0] addr;
  input wire [1:0] mode;
  output reg [31:0] next_addr;
  // modes other than increment and decrement hold the address (fixed port)
  always @* begin
    case (mode)
      `DMACH_AMODE_INC: next_addr = addr + `DMACH_ADDR_STEP;
      `DMACH_AMODE_DEC: next_addr = addr - `DMACH_ADDR_STEP;
      default: next_addr = addr;
    endcase
  end
endmodule // dmach_addr_step

/* File: core/dmach_defines.vh */
// register offsets, field positions, reset values and codes of the dma channel
`ifndef DMACH_DEFINES_VH
`define DMACH_DEFINES_VH
`define DMACH_OFF_CTRL 12'h000
`define DMACH_OFF_SRC_START 12'h004
`define DMACH_OFF_DST_START 12'h008
`define DMACH_OFF_COUNT 12'h00C
`define DMACH_OFF_CUR_SRC 12'h010
`define DMACH_OFF_CUR_DST 12'h014
`define DMACH_OFF_INT_STATUS 12'h018
`define DMACH_OFF_INT_ENABLE 12'h01C
`define DMACH_OFF_INT_CLEAR 12'h020
`define DMACH_OFF_PEND 12'h024
`define DMACH_OFF_DESC_BASE 12'h028
`define DMACH_OFF_STATE 12'h02C
`define DMACH_CTRL_EN 0
`define DMACH_CTRL_INIT 1
`define DMACH_CTRL_METHOD 2
`define DMACH_CTRL_DIR_LO 4
`define DMACH_CTRL_SMODE_LO 6
`define DMACH_CTRL_DMODE_LO 8
`define DMACH_CTRL_RST 10'h000
`define DMACH_DIR_MEM2DEV 2'h0
`define DMACH_DIR_MEM2MEM 2'h1
`define DMACH_DIR_DEV2MEM 2'h2
`define DMACH_AMODE_INC 2'h0
`define DMACH_AMODE_DEC 2'h1
`define DMACH_ADDR_STEP 32'h00000004
`define DMACH_IRQ_DONE 0
`define DMACH_IRQ_START 1
`define DMACH_IRQ_DESC 2
`define DMACH_IRQ_HALT 3
`define DMACH_IRQ_CLR_ALL 4'hF
`define DMACH_DESC_BUF_FULL 5
`define DMACH_DESC_CONT 4
`define DMACH_DESC_IRQ 2
`define DMACH_ACT_NEXT 2'h1
`define DMACH_ACT_RESTART 2'h2
`define DMACH_STRIDE_DEV 32'h00000008
`define DMACH_STRIDE_M2M 32'h00000010
`endif

/* File: core/dmach_pend_cnt.v */
// pending device request counter
`timescale 1ns/1ps
module dmach_pend_cnt #(
  parameter W = 8
) (
  clk,
  resetn,
  ce,
  clear,
  enable,
  req,
  take,
  count,
  nonzero
);
  input wire clk;
  input wire resetn;
  input wire ce;
  input wire clear;
  input wire enable;
  input wire req;
  input wire take;
  output reg [W-1:0] count;
  output wire nonzero;
  wire inc;
  wire dec;
  // saturate rather than wrap, a wrap would silently drop a burst of requests
  assign inc = enable && req && (count != {W{1'b1}});
  assign dec = take && (count != {W{1'b0}});
  assign nonzero = (count != {W{1'b0}});
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      count <= {W{1'b0}};
    end else if (ce) begin
      if (clear) begin
        count <= {W{1'b0}}; // R8
      end else if (inc && !dec) begin
        count <= count + {{(W-1){1'b0}}, 1'b1}; // R9
      end else if (dec && !inc) begin
        count <= count - {{(W-1){1'b0}}, 1'b1};
      end
    end
  end
endmodule // dmach_pend_cnt

/* File: core/dmach_top.v */
// dma channel: apb registers, direct and descriptor mode sequencer, bus master
//
// Summary of operation
// R1: direction 10 is device-to-memory; no source memory address is used.
// R2: direction 00 is memory-to-device; no destination memory address is used.
// R3: host loads source start address for memory-sourced transfers before starting.
// R4: host loads destination start address for memory-targeted transfers before starting.
// R5: after every word, current addresses move per their update mode fields.
// R6: writing 0xF to interrupt clear wipes all latched interrupt bits.
// R7: an enabled interrupt condition sets its status bit and raises irq.
// R8: setting enable clears the pending request counter; requests then count.
// R9: requests while enabled but uninitialized are counted, serviced only after init.
// R10: setting init copies start addresses and count into working registers.
// R11: hardware clears init once the initialized transfer has started.
// R12: at transfer end, pending init continues at once, otherwise channel stops.
// R13: host reprograms only after init reads zero or its interrupt is set.
// R14: method bit set selects descriptor mode, parameters from memory table.
// R15: descriptor entry loads on init or when previous entry completes.
// R16: descriptor init starts fetching at the descriptor table base.
// R17: each entry loads needed addresses plus transfer count into working registers.
// R18: after an entry, its buffer status and action fields pick the next step.
// R19: chained entries run until one says halt or restart from table start.
// R20: channels sharing a table base value read the same table.
// R21: device entries are 8 bytes: address at 0, control word at 4.
// R22: memory-to-memory entries are 16 bytes: source 0, destination 8, control 12.
// R23: host loads the count as bytes to move minus one.
// R24: control bit 5 set after device-to-memory entry, cleared after memory-to-device.
//
// The address map and register access over APB were left to the implementer.
`timescale 1ns/1ps
`include "dmach_defines.vh"
module dmach_top #(
  parameter PEND_W = 8
) (
  clk,
  resetn,
  ce,
  psel,
  penable,
  pwrite,
  paddr,
  pwdata,
  prdata,
  pready,
  pslverr,
  mem_req,
  mem_we,
  mem_addr,
  mem_wdata,
  mem_rdata,
  mem_ack,
  dev_req,
  dev_ack,
  dev_rdata,
  dev_wdata,
  irq
);
  input wire clk;
  input wire resetn;
  input wire ce;
  input wire psel;
  input wire penable;
  input wire pwrite;
  input wire [11:0] paddr;
  input wire [31:0] pwdata;
  output reg [31:0] prdata;
  output reg pready;
  output reg pslverr;
  output reg mem_req;
  output reg mem_we;
  output reg [31:0] mem_addr;
  output reg [31:0] mem_wdata;
  input wire [31:0] mem_rdata;
  input wire mem_ack;
  input wire dev_req;
  output reg dev_ack;
  input wire [31:0] dev_rdata;
  output reg [31:0] dev_wdata;
  output reg irq;

  localparam [3:0] ST_IDLE = 4'h0;
  localparam [3:0] ST_FETCH = 4'h1;
  localparam [3:0] ST_FRD = 4'h2;
  localparam [3:0] ST_UNIT = 4'h3;
  localparam [3:0] ST_MRD = 4'h4;
  localparam [3:0] ST_MWR = 4'h5;
  localparam [3:0] ST_DCAP = 4'h6;
  localparam [3:0] ST_STEP = 4'h7;
  localparam [3:0] ST_WB = 4'h8;
  localparam [3:0] ST_DONE = 4'h9;
  localparam [3:0] ST_DWAIT = 4'hA;

  reg [9:0] ctrl_q;
  reg [31:0] src_start_q;
  reg [31:0] dst_start_q;
  reg [15:0] count_start_q;
  reg [31:0] cur_src_q;
  reg [31:0] cur_dst_q;
  reg [15:0] cnt_q;
  reg [15:0] cnt_load_q;
  reg [3:0] int_stat_q;
  reg [3:0] int_en_q;
  reg [31:0] desc_base_q;
  reg [31:0] entry_q;
  reg [1:0] foff_q;
  reg [31:0] desc_ctrl_q;
  reg [31:0] data_q;
  reg [3:0] state_q;
  reg [3:0] int_set;
  reg pend_take;
  reg [31:0] rd_mux;
  reg rd_hit;

  wire en = ctrl_q[`DMACH_CTRL_EN];
  wire init = ctrl_q[`DMACH_CTRL_INIT];
  wire method = ctrl_q[`DMACH_CTRL_METHOD];
  wire [1:0] dir = ctrl_q[`DMACH_CTRL_DIR_LO+1:`DMACH_CTRL_DIR_LO];
  wire [1:0] smode = ctrl_q[`DMACH_CTRL_SMODE_LO+1:`DMACH_CTRL_SMODE_LO];
  wire [1:0] dmode = ctrl_q[`DMACH_CTRL_DMODE_LO+1:`DMACH_CTRL_DMODE_LO];
  wire is_m2d = (dir == `DMACH_DIR_MEM2DEV); // R2
  wire is_d2m = (dir == `DMACH_DIR_DEV2MEM); // R1
  wire is_m2m = !is_m2d && !is_d2m;
  wire src_is_mem = !is_d2m;
  wire dst_is_mem = !is_m2d;
  wire [31:0] stride = is_m2m ? `DMACH_STRIDE_M2M : `DMACH_STRIDE_DEV;
  wire [1:0] ctrl_word = is_m2m ? 2'h3 : 2'h1;
  wire apb_setup = psel && !penable;
  wire apb_wr = psel && penable && pready && pwrite;
  wire [PEND_W-1:0] pend_cnt;
  wire pend_nz;
  wire [31:0] src_next;
  wire [31:0] dst_next;
  wire wr_ctrl = apb_wr && (paddr == `DMACH_OFF_CTRL);
  wire en_rise = wr_ctrl && pwdata[`DMACH_CTRL_EN] && !en;
  wire launch = en && init &&
    ((state_q == ST_IDLE) || (state_q == ST_DONE) || (state_q == ST_DWAIT));
  wire [31:0] desc_addr = entry_q + {28'h0000000, foff_q, 2'b00};
  wire [1:0] foff_next = (is_m2m && (foff_q == 2'h0)) ? 2'h2 : (foff_q + 2'h1);

  dmach_pend_cnt #(
    .W(PEND_W)
  ) u_pend (
    .clk(clk),
    .resetn(resetn),
    .ce(ce),
    .clear(en_rise),
    .enable(en),
    .req(dev_req),
    .take(pend_take),
    .count(pend_cnt),
    .nonzero(pend_nz)
  );

  dmach_addr_step u_src_step (
    .addr(cur_src_q),
    .mode(smode),
    .next_addr(src_next)
  );

  dmach_addr_step u_dst_step (
    .addr(cur_dst_q),
    .mode(dmode),
    .next_addr(dst_next)
  );

  // register read mux; state word exposes sequencer for debug
  always @* begin
    rd_mux = 32'h00000000;
    rd_hit = 1'b1;
    case (paddr)
      `DMACH_OFF_CTRL: rd_mux = {22'h000000, ctrl_q};
      `DMACH_OFF_SRC_START: rd_mux = src_start_q;
      `DMACH_OFF_DST_START: rd_mux = dst_start_q;
      `DMACH_OFF_COUNT: rd_mux = {16'h0000, count_start_q};
      `DMACH_OFF_CUR_SRC: rd_mux = cur_src_q;
      `DMACH_OFF_CUR_DST: rd_mux = cur_dst_q;
      `DMACH_OFF_INT_STATUS: rd_mux = {28'h0000000, int_stat_q};
      `DMACH_OFF_INT_ENABLE: rd_mux = {28'h0000000, int_en_q};
      `DMACH_OFF_INT_CLEAR: rd_mux = 32'h00000000;
      `DMACH_OFF_PEND: rd_mux = {{(32-PEND_W){1'b0}}, pend_cnt};
      `DMACH_OFF_DESC_BASE: rd_mux = desc_base_q;
      `DMACH_OFF_STATE: rd_mux = {12'h000, cnt_q, state_q};
      default: rd_hit = 1'b0;
    endcase
  end

  // apb slave: one wait-free access phase, answer prepared in the setup cycle
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      prdata <= 32'h00000000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end else if (ce) begin
      pready <= apb_setup;
      if (apb_setup) begin
        prdata <= pwrite ? 32'h00000000 : rd_mux;
        pslverr <= !rd_hit;
      end else begin
        pslverr <= 1'b0;
      end
    end
  end

  // static software registers; start values stay untouched while a transfer runs
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      src_start_q <= 32'h00000000;
      dst_start_q <= 32'h00000000;
      count_start_q <= 16'h0000;
      int_en_q <= 4'h0;
      desc_base_q <= 32'h00000000;
    end else if (ce && apb_wr) begin
      case (paddr)
        `DMACH_OFF_SRC_START: src_start_q <= pwdata; // R3
        `DMACH_OFF_DST_START: dst_start_q <= pwdata; // R4
        `DMACH_OFF_COUNT: count_start_q <= pwdata[15:0]; // R23
        `DMACH_OFF_INT_ENABLE: int_en_q <= pwdata[3:0];
        `DMACH_OFF_DESC_BASE: desc_base_q <= pwdata; // R20
        default: ;
      endcase
    end
  end

  // interrupt status: new events win over a clear in the same cycle
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      int_stat_q <= 4'h0;
      irq <= 1'b0;
    end else if (ce) begin
      if (apb_wr && (paddr == `DMACH_OFF_INT_CLEAR)) begin
        int_stat_q <= (int_stat_q & ~pwdata[3:0]) | (int_set & int_en_q); // R6
      end else begin
        int_stat_q <= int_stat_q | (int_set & int_en_q); // R7
      end
      irq <= |(int_stat_q | (int_set & int_en_q)); // R7
    end
  end

  // interrupt events of this cycle
  always @* begin
    int_set = 4'h0;
    int_set[`DMACH_IRQ_START] = launch;
    if (state_q == ST_DONE) begin
      int_set[`DMACH_IRQ_DONE] = 1'b1;
      int_set[`DMACH_IRQ_DESC] = method && desc_ctrl_q[`DMACH_DESC_IRQ];
      int_set[`DMACH_IRQ_HALT] = method && !init &&
        (desc_ctrl_q[1:0] != `DMACH_ACT_NEXT) && (desc_ctrl_q[1:0] != `DMACH_ACT_RESTART);
    end
  end

  // one pending request is consumed per device word
  always @* begin
    pend_take = (state_q == ST_UNIT) && !is_m2m && pend_nz; // R9
  end

  // control register; init is set by software and cleared when the transfer starts
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ctrl_q <= `DMACH_CTRL_RST;
    end else if (ce) begin
      if (wr_ctrl) begin
        ctrl_q <= pwdata[9:0]; // R14
        ctrl_q[`DMACH_CTRL_INIT] <= pwdata[`DMACH_CTRL_INIT] || (init && !launch); // R13
      end else if (launch) begin
        ctrl_q[`DMACH_CTRL_INIT] <= 1'b0; // R11
      end
    end
  end

  // transfer sequencer and memory bus master
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= ST_IDLE;
      cur_src_q <= 32'h00000000;
      cur_dst_q <= 32'h00000000;
      cnt_q <= 16'h0000;
      cnt_load_q <= 16'h0000;
      entry_q <= 32'h00000000;
      foff_q <= 2'h0;
      desc_ctrl_q <= 32'h00000000;
      data_q <= 32'h00000000;
      mem_req <= 1'b0;
      mem_we <= 1'b0;
      mem_addr <= 32'h00000000;
      mem_wdata <= 32'h00000000;
      dev_ack <= 1'b0;
      dev_wdata <= 32'h00000000;
    end else if (ce) begin
      dev_ack <= 1'b0;
      if (!en) begin
        // clearing enable aborts; an open memory cycle is dropped
        state_q <= ST_IDLE;
        mem_req <= 1'b0;
      end else if (launch) begin
        if (method) begin
          entry_q <= desc_base_q; // R16
          foff_q <= 2'h0;
          state_q <= ST_FETCH; // R15
        end else begin
          cur_src_q <= src_start_q; // R10
          cur_dst_q <= dst_start_q; // R10
          cnt_q <= count_start_q; // R10
          cnt_load_q <= count_start_q;
          state_q <= ST_UNIT; // R12
        end
      end else begin
        case (state_q)
          ST_IDLE: ;
          ST_FETCH: begin
            mem_req <= 1'b1;
            mem_we <= 1'b0;
            mem_addr <= desc_addr; // R21 R22
            state_q <= ST_FRD;
          end
          ST_FRD: begin
            if (mem_ack) begin
              mem_req <= 1'b0;
              if (foff_q == ctrl_word) begin
                desc_ctrl_q <= mem_rdata;
                cnt_q <= mem_rdata[31:16]; // R17
                cnt_load_q <= mem_rdata[31:16];
                state_q <= ST_UNIT;
              end else begin
                if (foff_q == 2'h2 || is_d2m) begin
                  cur_dst_q <= mem_rdata; // R17
                end else begin
                  cur_src_q <= mem_rdata; // R17
                end
                foff_q <= foff_next; // R22
                state_q <= ST_FETCH;
              end
            end
          end
          ST_UNIT: begin
            if (is_m2m || pend_nz) begin
              if (is_d2m) begin
                dev_ack <= 1'b1;
                state_q <= ST_DCAP;
              end else begin
                mem_req <= 1'b1;
                mem_we <= 1'b0;
                mem_addr <= cur_src_q;
                state_q <= ST_MRD;
              end
            end
          end
          ST_DCAP: begin
            mem_req <= 1'b1;
            mem_we <= 1'b1;
            mem_addr <= cur_dst_q;
            mem_wdata <= dev_rdata;
            state_q <= ST_MWR;
          end
          ST_MRD: begin
            if (mem_ack) begin
              mem_req <= 1'b0;
              data_q <= mem_rdata;
              if (is_m2d) begin
                dev_wdata <= mem_rdata;
                dev_ack <= 1'b1;
                state_q <= ST_STEP;
              end else begin
                mem_req <= 1'b1;
                mem_we <= 1'b1;
                mem_addr <= cur_dst_q;
                mem_wdata <= mem_rdata;
                state_q <= ST_MWR;
              end
            end
          end
          ST_MWR: begin
            if (mem_ack) begin
              mem_req <= 1'b0;
              mem_we <= 1'b0;
              state_q <= ST_STEP;
            end
          end
          ST_STEP: begin
            if (src_is_mem) begin
              cur_src_q <= src_next; // R5
            end
            if (dst_is_mem) begin
              cur_dst_q <= dst_next; // R5
            end
            if (cnt_q < 16'h0004) begin
              cnt_q <= 16'h0000;
              state_q <= (method && !is_m2m) ? ST_WB : ST_DONE;
            end else begin
              cnt_q <= cnt_q - 16'h0004;
              state_q <= ST_UNIT;
            end
          end
          ST_WB: begin
            // buffer status written back into the entry's control word
            if (!mem_req) begin
              mem_req <= 1'b1;
              mem_we <= 1'b1;
              mem_addr <= entry_q + {28'h0000000, ctrl_word, 2'b00}; // R21
              mem_wdata <= {cnt_load_q, desc_ctrl_q[15:6], is_d2m, desc_ctrl_q[4:0]}; // R24
              desc_ctrl_q[`DMACH_DESC_BUF_FULL] <= is_d2m; // R24
            end else if (mem_ack) begin
              mem_req <= 1'b0;
              mem_we <= 1'b0;
              state_q <= ST_DONE;
            end
          end
          ST_DONE: begin
            // reached only without a pending init, which launch serves first
            if (!method) begin
              state_q <= ST_IDLE; // R12
            end else begin
              foff_q <= 2'h0;
              case (desc_ctrl_q[1:0])
                `DMACH_ACT_NEXT: begin
                  entry_q <= entry_q + stride; // R18 R21 R22
                  state_q <= desc_ctrl_q[`DMACH_DESC_CONT] ? ST_FETCH : ST_DWAIT; // R18
                end
                `DMACH_ACT_RESTART: begin
                  entry_q <= desc_base_q; // R19
                  state_q <= desc_ctrl_q[`DMACH_DESC_CONT] ? ST_FETCH : ST_DWAIT;
                end
                default: state_q <= ST_IDLE; // R19
              endcase
            end
          end
          ST_DWAIT: begin
            // a non-continuous entry waits for a request before the next fetch
            if (pend_nz) begin
              state_q <= ST_FETCH; // R15
            end
          end
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end
endmodule // dmach_top

/* File: verification/dma_channel_direct_descriptor_test.sv */
// self-checking testbench of the dma channel
`timescale 1ns/1ps
`include "dmach_defines.vh"
`define CHK(g, e, m) begin checked++; if ((g) !== (e)) begin n_fail++; \
  $display("CHECK FAILED t=%0t %s", $time, m); end end
module dma_channel_direct_descriptor_test;
  logic clk, resetn, psel, penable, pwrite, slow, dev_req, rerr;
  logic [11:0] paddr;
  logic [31:0] pwdata, rq, dev_word, d0, d1, dev_got;
  logic [31:0] dev_hist [0:7];
  wire [31:0] prdata, mem_addr, mem_wdata, mem_rdata, dev_wdata, dev_rdata;
  wire pready, pslverr, mem_req, mem_we, mem_ack, dev_ack, irq;
  int n_fail, checked, n_ack, i, m;
  dmach_top u_dut (.clk(clk), .resetn(resetn), .ce(1'b1), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .mem_req(mem_req), .mem_we(mem_we), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_rdata(mem_rdata), .mem_ack(mem_ack), .dev_req(dev_req),
    .dev_ack(dev_ack), .dev_rdata(dev_rdata), .dev_wdata(dev_wdata), .irq(irq));
  dmach_mem_model u_mem (.clk(clk), .resetn(resetn), .slow(slow), .mem_req(mem_req),
    .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
    .mem_ack(mem_ack));
  // device data only valid in the ack cycle, inverse otherwise
  assign dev_rdata = dev_ack ? dev_word : ~dev_word;
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    if (dev_ack === 1'b1) begin
      dev_hist[n_ack[2:0]] <= dev_word;
      dev_got <= dev_wdata;
      n_ack <= n_ack + 1;
      dev_word <= $urandom;
    end
  end
  function automatic logic [31:0] step(input logic [31:0] a, input int md, input int k);
    return (md != 0) ? a - 32'(4 * k) : a + 32'(4 * k);
  endfunction
  task summarize;
    $display("checks %0d failures %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task timeout_fail;
    n_fail++;
    $display("CHECK FAILED t=%0t wait timed out", $time);
    summarize();
  endtask
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    begin
      n = 0;
      @(posedge clk);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      do begin
        @(posedge clk);
        n++;
      end while (pready !== 1'b1 && n < 20);
      rq = prdata;
      rerr = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      if (n >= 20) timeout_fail();
    end
  endtask
  task wait_st(input int b);
    int n;
    begin
      n = 0;
      rq = 32'h0;
      while (rq[b] !== 1'b1 && n < 300) begin
        apb(1'b0, `DMACH_OFF_INT_STATUS, 32'h0);
        n++;
      end
      if (n >= 300) timeout_fail();
    end
  endtask
  task pulse(input int k);
    repeat (k) begin
      @(posedge clk);
      dev_req <= 1'b1;
      @(posedge clk);
      dev_req <= 1'b0;
      repeat ($urandom % 3) @(posedge clk);
    end
  endtask
  initial begin
    resetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    slow = 1'b0;
    dev_req = 1'b0;
    dev_word = 32'h0;
    n_ack = 0;
    n_fail = 0;
    checked = 0;
    void'($urandom(87194));
    repeat (2) @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, `DMACH_OFF_CTRL, 32'h0);
    `CHK(rq, 32'h0, "control reset value")
    apb(1'b0, 12'h030, 32'h0);
    `CHK({rerr, rq}, {1'b1, 32'h0}, "unmapped read")
    $display("test registers done");
    // memory-to-memory, increment then decrement, fast then slow memory
    apb(1'b1, `DMACH_OFF_INT_ENABLE, 32'hF);
    for (m = 0; m < 2; m++) begin
      slow <= m[0];
      for (i = 0; i < 3; i++) u_mem.mem[step(32'h108, m, i) >> 2] = $urandom;
      apb(1'b1, `DMACH_OFF_INT_CLEAR, 32'hF);
      apb(1'b1, `DMACH_OFF_SRC_START, 32'h108);
      apb(1'b1, `DMACH_OFF_DST_START, 32'h208);
      apb(1'b1, `DMACH_OFF_COUNT, 32'd11);
      apb(1'b1, `DMACH_OFF_CTRL, {22'h0, m[1:0], m[1:0], 6'h13});
      wait_st(`DMACH_IRQ_DONE);
      for (i = 0; i < 3; i++)
        `CHK(u_mem.mem[step(32'h208, m, i) >> 2], u_mem.mem[step(32'h108, m, i) >> 2], "m2m")
      apb(1'b0, `DMACH_OFF_CUR_SRC, 32'h0);
      `CHK(rq, step(32'h108, m, 3), "current source")
      apb(1'b0, `DMACH_OFF_CUR_DST, 32'h0);
      `CHK(rq, step(32'h208, m, 3), "current destination")
      apb(1'b0, `DMACH_OFF_CTRL, 32'h0);
      `CHK(rq[`DMACH_CTRL_INIT], 1'b0, "init self clear")
      `CHK(irq, 1'b1, "irq raised")
      apb(1'b1, `DMACH_OFF_INT_CLEAR, 32'hF);
      apb(1'b0, `DMACH_OFF_INT_STATUS, 32'h0);
      `CHK(rq[3:0], 4'h0, "status cleared")
      `CHK(irq, 1'b0, "irq dropped")
    end
    $display("test direct copy done");
    // device-to-memory: requests held back until init, start bit masked
    slow <= 1'b1;
    apb(1'b1, `DMACH_OFF_INT_ENABLE, 32'h1);
    apb(1'b1, `DMACH_OFF_CTRL, 32'h21);
    pulse(3);
    apb(1'b0, `DMACH_OFF_PEND, 32'h0);
    `CHK(rq, 32'd3, "pending count")
    `CHK(n_ack, 0, "no service before init")
    apb(1'b1, `DMACH_OFF_CTRL, 32'h20);
    apb(1'b1, `DMACH_OFF_CTRL, 32'h21);
    apb(1'b0, `DMACH_OFF_PEND, 32'h0);
    `CHK(rq, 32'h0, "enable clears pending")
    apb(1'b1, `DMACH_OFF_DST_START, 32'h300);
    apb(1'b1, `DMACH_OFF_COUNT, 32'd7);
    pulse(2);
    apb(1'b1, `DMACH_OFF_CTRL, 32'h23);
    wait_st(`DMACH_IRQ_DONE);
    `CHK(rq[3:0], 4'h1, "only enabled bit latched")
    `CHK(u_mem.mem[10'h0C0], dev_hist[0], "device word 0")
    `CHK(u_mem.mem[10'h0C1], dev_hist[1], "device word 1")
    $display("test device to memory done");
    // descriptor chain: copy entry continues to second entry which halts
    apb(1'b1, `DMACH_OFF_INT_ENABLE, 32'hF);
    apb(1'b1, `DMACH_OFF_INT_CLEAR, 32'hF);
    u_mem.mem[10'h100] = 32'h500;
    u_mem.mem[10'h102] = 32'h600;
    u_mem.mem[10'h103] = 32'h0003_0011;
    u_mem.mem[10'h104] = 32'h504;
    u_mem.mem[10'h106] = 32'h604;
    u_mem.mem[10'h107] = 32'h0003_0000;
    d0 = $urandom;
    d1 = $urandom;
    u_mem.mem[10'h140] = d0;
    u_mem.mem[10'h141] = d1;
    apb(1'b1, `DMACH_OFF_DESC_BASE, 32'h400);
    apb(1'b1, `DMACH_OFF_CTRL, 32'h17);
    wait_st(`DMACH_IRQ_HALT);
    `CHK(u_mem.mem[10'h180], d0, "entry 0 copy")
    `CHK(u_mem.mem[10'h181], d1, "entry 1 copy")
    // descriptor device-to-memory entry writes back the buffer flag
    u_mem.mem[10'h120] = 32'h700;
    u_mem.mem[10'h121] = 32'h0003_0000;
    apb(1'b1, `DMACH_OFF_INT_CLEAR, 32'hF);
    apb(1'b1, `DMACH_OFF_DESC_BASE, 32'h480);
    apb(1'b1, `DMACH_OFF_CTRL, 32'h25);
    pulse(1);
    apb(1'b1, `DMACH_OFF_CTRL, 32'h27);
    wait_st(`DMACH_IRQ_HALT);
    `CHK(u_mem.mem[10'h1C0], dev_hist[2], "descriptor device word")
    `CHK(u_mem.mem[10'h121][`DMACH_DESC_BUF_FULL], 1'b1, "buffer full flag")
    $display("test descriptor done");
    // memory-to-device: word read from memory shows on the device data port
    d0 = $urandom;
    u_mem.mem[10'h0D0] = d0;
    apb(1'b1, `DMACH_OFF_INT_CLEAR, 32'hF);
    apb(1'b1, `DMACH_OFF_SRC_START, 32'h340);
    apb(1'b1, `DMACH_OFF_COUNT, 32'd3);
    apb(1'b1, `DMACH_OFF_CTRL, 32'h3);
    pulse(1);
    wait_st(`DMACH_IRQ_DONE);
    `CHK(dev_got, d0, "device write word")
    apb(1'b0, `DMACH_OFF_CUR_SRC, 32'h0);
    `CHK(rq, 32'h344, "current source m2d")
    resetn <= 1'b0;
    @(posedge clk);
    resetn <= 1'b1;
    apb(1'b0, `DMACH_OFF_CTRL, 32'h0);
    `CHK(rq, 32'h0, "control after reset")
    $display("test memory to device and reset done");
    summarize();
  end
endmodule // dma_channel_direct_descriptor_test

/* File: verification/dmach_mem_model.sv */
// system memory partner on the channel's bus master port
`timescale 1ns/1ps
module dmach_mem_model (
  input logic clk,
  input logic resetn,
  input logic slow,
  input logic mem_req,
  input logic mem_we,
  input logic [31:0] mem_addr,
  input logic [31:0] mem_wdata,
  output logic [31:0] mem_rdata,
  output logic mem_ack
);
  logic [31:0] mem [0:1023];
  logic [31:0] rd_q;
  logic [1:0] dly;
  logic ack_q;
  assign mem_ack = ack_q;
  // outside the ack cycle the bus shows the inverse so stale data never matches
  assign mem_rdata = ack_q ? rd_q : ~rd_q;
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ack_q <= 1'b0;
      dly <= 2'h0;
      rd_q <= 32'h0;
    end else if (ack_q) begin
      ack_q <= 1'b0;
    end else if (mem_req && dly >= (slow ? 2'h3 : 2'h0)) begin
      ack_q <= 1'b1;
      dly <= 2'h0;
      if (mem_we) mem[mem_addr[11:2]] <= mem_wdata;
      else rd_q <= mem[mem_addr[11:2]];
    end else if (mem_req) begin
      dly <= dly + 2'h1;
    end
  end
endmodule // dmach_mem_model

/* File: verification/dmach_props.sv */
// port-level assertion checker for the dma channel
`timescale 1ns/1ps
module dmach_props #(
  parameter PEND_W = 8
) (
  input logic clk,
  input logic resetn,
  input logic ce,
  input logic psel,
  input logic penable,
  input logic pready,
  input logic pslverr,
  input logic mem_req,
  input logic mem_we,
  input logic [31:0] mem_addr,
  input logic [31:0] mem_wdata,
  input logic [31:0] mem_rdata,
  input logic mem_ack,
  input logic dev_ack,
  input logic irq
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!resetn);
  apb_answer_a: assert property (psel && !penable && ce |=> pready)
    else $error("no pready after setup");
  ready_pulse_a: assert property (pready && ce |=> !pready)
    else $error("pready longer than one cycle");
  ready_cause_a: assert property (pready |-> $past(psel && !penable))
    else $error("pready without setup");
  slverr_ready_a: assert property (pslverr |-> pready)
    else $error("pslverr without pready");
  mem_hold_a: assert property (mem_req && !mem_ack |=> mem_req && $stable(mem_addr)
    && $stable(mem_we) && $stable(mem_wdata)) else $error("memory request changed");
  mem_release_a: assert property (mem_req && mem_ack |=> !mem_req
    || (mem_we && !$past(mem_we))) else $error("memory request not released");
  copy_data_a: assert property (mem_req && mem_ack && !mem_we ##1 mem_req && mem_we
    |-> mem_wdata == $past(mem_rdata)) else $error("copied word differs");
  dev_pulse_a: assert property (dev_ack |=> !dev_ack)
    else $error("device ack longer than one cycle");
  reset_quiet_a: assert property ($rose(resetn) |-> !mem_req && !dev_ack && !irq)
    else $error("outputs active after reset");
endmodule // dmach_props
bind dmach_top dmach_props #(.PEND_W(PEND_W)) u_props (.clk(clk), .resetn(resetn), .ce(ce),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr), .mem_req(mem_req),
  .mem_we(mem_we), .mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
  .mem_ack(mem_ack), .dev_ack(dev_ack), .irq(irq));
